/* File: hw/bsf_pkg.sv */
package bsf_pkg;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_FREQ_KHZ = 100000;
    localparam int OSC_FREQ_KHZ = 2500;
    localparam int OSC_DIV = CLK_FREQ_KHZ / OSC_FREQ_KHZ;
    localparam int STEP_TIME_NS = 20000;
    localparam int CLK_PERIOD_NS = 10;
    localparam int STEP_CYCLES = (STEP_TIME_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    localparam int FOLDBACK_CYCLES = 32;
    localparam int SYNC_STAGES = 2;

    // ----------------------------------------
    // Current limit level codes for the analog limit DAC
    // ----------------------------------------
    localparam logic [1:0] LIM_20 = 2'h0;
    localparam logic [1:0] LIM_25 = 2'h1;
    localparam logic [1:0] LIM_40 = 2'h2;
    localparam logic [1:0] LIM_100 = 2'h3;

    typedef enum logic [3:0] {
        BSF_OFF,
        BSF_REF,
        BSF_LVL1,
        BSF_LVL2,
        BSF_LVL3,
        BSF_LVL4,
        BSF_SS_WAIT,
        BSF_PWM,
        BSF_THERMAL
    } bsf_state_e;

    // Comparator outputs from the analog stage
    typedef struct packed {
        logic enable;
        logic uvloOk;
        logic overTemp;
        logic tempRecovered;
        logic curLimit;
        logic zeroCurrent;
        logic outAbove90;
        logic outAbove96;
        logic overVoltage;
        logic belowHold;
    } bsf_sense_s;

    // Drive to the power stage
    typedef struct packed {
        logic highSideOn;
        logic lowSideOn;
        logic refOn;
        logic foldback;
        logic hysteretic;
        logic [1:0] limitLevel;
    } bsf_drive_s;

endpackage

/* File: hw/bsf_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module bsf_sync #(
    parameter int WIDTH = 10
) (
    input wire logic clock, // System clock
    input wire logic sys_rst, // Synchronous reset
    input wire logic [WIDTH-1:0] asyncIn, // Pins from other domain
    output logic [WIDTH-1:0] syncOut // Synchronised copy
);

    logic [WIDTH-1:0] meta_q;

    // Only the second stage is visible to logic
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            meta_q <= '0;
            syncOut <= '0;
        end else begin
            meta_q <= asyncIn;
            syncOut <= meta_q;
        end
    end

endmodule

`default_nettype wire

/* File: hw/bsf_supervisor.sv */
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - PWM turns high side on each oscillator edge
// - Over temperature floats switch node
// - Temperature recovery restarts full soft-start
// - 32 consecutive limit cycles enter foldback
// - Foldback ends when load below hold
// - No foldback during soft-start
// - Overvoltage disables drive, node floats
// - Start only with supply ok and enable
// - Limit steps 20, 25, 40, 100 percent
// - 20us reference wait, then 20us per level
// - Hysteretic on at zero, off at limit
// - Early 90 percent stays hysteretic until end
// - Late start goes PWM at 96 percent
// - End of soft-start forces PWM
// - No discharge of prebiased output
// - Enable low shuts everything off at once
module bsf_supervisor #(
    parameter int STEP_CYCLES = bsf_pkg::STEP_CYCLES,
    parameter int OSC_DIV = bsf_pkg::OSC_DIV
) (
    input wire logic clock, // 100 MHz system clock
    input wire logic sys_rst, // Synchronous reset, active high
    input wire bsf_pkg::bsf_sense_s sense, // Raw comparator inputs
    output bsf_pkg::bsf_drive_s drive, // Power stage controls
    output logic oscTick // Internal oscillator pulse
);

    // ----------------------------------------
    // Input synchronisation
    // ----------------------------------------
    bsf_pkg::bsf_sense_s sn;
    logic [$bits(bsf_pkg::bsf_sense_s)-1:0] snBits;

    bsf_sync #(.WIDTH($bits(bsf_pkg::bsf_sense_s))) uSync (
        .clock(clock),
        .sys_rst(sys_rst),
        .asyncIn(sense),
        .syncOut(snBits)
    );
    assign sn = bsf_pkg::bsf_sense_s'(snBits);

    // ----------------------------------------
    // Oscillator
    // ----------------------------------------
    logic [7:0] oscCnt_q;
    logic oscEdge;

    assign oscEdge = (oscCnt_q == 8'(OSC_DIV - 1));

    always_ff @(posedge clock) begin
        if (sys_rst || oscEdge) begin
            oscCnt_q <= 8'h00;
        end else begin
            oscCnt_q <= oscCnt_q + 8'h01;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            oscTick <= 1'b0;
        end else begin
            oscTick <= oscEdge;
        end
    end

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    bsf_pkg::bsf_state_e state_q;
    logic [15:0] stepCnt_q;
    logic stepDone;
    logic early90_q;
    logic inSoftStart;
    logic shutdown;
    logic waitSlot_q;

    assign stepDone = (stepCnt_q == 16'(STEP_CYCLES - 1));
    assign shutdown = !sn.enable || !sn.uvloOk;
    assign inSoftStart = (state_q != bsf_pkg::BSF_PWM) &&
        (state_q != bsf_pkg::BSF_OFF) &&
        (state_q != bsf_pkg::BSF_THERMAL);

    always_ff @(posedge clock) begin
        // A slot only starts on entry to the reference wait, so a long
        // thermal hysteresis cannot shorten it
        if (sys_rst || shutdown || sn.overTemp || stepDone ||
            state_q == bsf_pkg::BSF_OFF ||
            state_q == bsf_pkg::BSF_THERMAL) begin
            stepCnt_q <= 16'h0000;
        end else begin
            stepCnt_q <= stepCnt_q + 16'h0001;
        end
    end

    // Faults are checked ahead of any sequencing step
    always_ff @(posedge clock) begin
        if (sys_rst || shutdown) begin
            state_q <= bsf_pkg::BSF_OFF;
        end else if (sn.overTemp) begin
            state_q <= bsf_pkg::BSF_THERMAL;
        end else begin
            case (state_q)
                bsf_pkg::BSF_OFF: begin
                    state_q <= bsf_pkg::BSF_REF;
                end
                bsf_pkg::BSF_THERMAL: begin
                    if (sn.tempRecovered) begin
                        state_q <= bsf_pkg::BSF_REF;
                    end
                end
                bsf_pkg::BSF_REF: begin
                    if (stepDone) begin
                        state_q <= bsf_pkg::BSF_LVL1;
                    end
                end
                bsf_pkg::BSF_LVL1: begin
                    if (stepDone) begin
                        state_q <= bsf_pkg::BSF_LVL2;
                    end
                end
                bsf_pkg::BSF_LVL2: begin
                    if (stepDone) begin
                        state_q <= (early90_q || sn.outAbove90) ?
                            bsf_pkg::BSF_SS_WAIT :
                            bsf_pkg::BSF_LVL3;
                    end
                end
                bsf_pkg::BSF_LVL3: begin
                    if (sn.outAbove96) begin
                        state_q <= bsf_pkg::BSF_PWM;
                    end else if (stepDone) begin
                        state_q <= bsf_pkg::BSF_LVL4;
                    end
                end
                bsf_pkg::BSF_LVL4: begin
                    if (sn.outAbove96 || stepDone) begin
                        state_q <= bsf_pkg::BSF_PWM;
                    end
                end
                bsf_pkg::BSF_SS_WAIT: begin
                    // Two remaining level slots keep the 100us total
                    if (stepDone && waitSlot_q) begin
                        state_q <= bsf_pkg::BSF_PWM;
                    end
                end
                default: begin
                    state_q <= bsf_pkg::BSF_PWM;
                end
            endcase
        end
    end

    // Wait slot counter: early finish still waits out two 20us slots
    always_ff @(posedge clock) begin
        if (sys_rst || state_q != bsf_pkg::BSF_SS_WAIT) begin
            waitSlot_q <= 1'b0;
        end else if (stepDone) begin
            waitSlot_q <= 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst || state_q == bsf_pkg::BSF_OFF ||
            state_q == bsf_pkg::BSF_REF) begin
            early90_q <= 1'b0;
        end else if ((state_q == bsf_pkg::BSF_LVL1 ||
                      state_q == bsf_pkg::BSF_LVL2) && sn.outAbove90) begin
            early90_q <= 1'b1;
        end
    end

    logic ssWaitEnd;
    assign ssWaitEnd = (state_q == bsf_pkg::BSF_SS_WAIT) && stepDone &&
        waitSlot_q;

    logic pwmMode_q;
    always_ff @(posedge clock) begin
        if (sys_rst || shutdown || sn.overTemp) begin
            pwmMode_q <= 1'b0;
        end else if (ssWaitEnd) begin
            pwmMode_q <= 1'b1;
        end else if (state_q == bsf_pkg::BSF_PWM) begin
            pwmMode_q <= 1'b1;
        end else begin
            pwmMode_q <= 1'b0;
        end
    end

    // ----------------------------------------
    // Foldback
    // ----------------------------------------
    logic [5:0] limCnt_q;
    logic limSeen_q;
    logic foldback_q;

    always_ff @(posedge clock) begin
        if (sys_rst || !pwmMode_q) begin
            limSeen_q <= 1'b0;
        end else if (oscEdge) begin
            limSeen_q <= 1'b0;
        end else if (sn.curLimit) begin
            limSeen_q <= 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst || !pwmMode_q) begin
            limCnt_q <= 6'h00;
        end else if (foldback_q && sn.belowHold) begin
            // Leaving foldback starts a fresh count, else it re-enters
            limCnt_q <= 6'h00;
        end else if (oscEdge) begin
            if (!(limSeen_q || sn.curLimit)) begin
                limCnt_q <= 6'h00;
            end else if (limCnt_q != 6'(bsf_pkg::FOLDBACK_CYCLES)) begin
                limCnt_q <= limCnt_q + 6'h01;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst || shutdown || sn.overTemp || inSoftStart) begin
            foldback_q <= 1'b0;
        end else if (foldback_q && sn.belowHold) begin
            foldback_q <= 1'b0;
        end else if (limCnt_q == 6'(bsf_pkg::FOLDBACK_CYCLES)) begin
            foldback_q <= 1'b1;
        end
    end

    // ----------------------------------------
    // Switch drive
    // ----------------------------------------
    logic hsOn_q;
    logic hystPhase;
    logic [1:0] level;

    assign hystPhase = inSoftStart && state_q != bsf_pkg::BSF_REF &&
        !pwmMode_q;

    always_comb begin
        case (state_q)
            bsf_pkg::BSF_LVL1: level = bsf_pkg::LIM_20;
            bsf_pkg::BSF_LVL2: level = bsf_pkg::LIM_25;
            bsf_pkg::BSF_LVL3: level = bsf_pkg::LIM_40;
            default: level = bsf_pkg::LIM_100;
        endcase
    end

    always_ff @(posedge clock) begin
        if (sys_rst || shutdown || sn.overTemp || sn.overVoltage) begin
            hsOn_q <= 1'b0;
        end else if (pwmMode_q) begin
            if (sn.curLimit) begin
                hsOn_q <= 1'b0;
            end else if (oscEdge) begin
                hsOn_q <= 1'b1;
            end
        end else if (hystPhase) begin
            if (sn.curLimit) begin
                hsOn_q <= 1'b0;
            end else if (sn.zeroCurrent) begin
                hsOn_q <= 1'b1;
            end
        end else begin
            hsOn_q <= 1'b0;
        end
    end

    // Low side conducts only in PWM; during soft-start it stays off so
    // inductor current never goes negative into a prebiased output.
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            drive <= '0;
        end else begin
            drive.highSideOn <= hsOn_q && !shutdown && !sn.overTemp &&
                !sn.overVoltage;
            drive.lowSideOn <= pwmMode_q && !hsOn_q && !shutdown &&
                !sn.overTemp && !sn.overVoltage;
            drive.refOn <= !shutdown;
            drive.foldback <= foldback_q;
            drive.hysteretic <= hystPhase;
            drive.limitLevel <= level;
        end
    end

endmodule

`default_nettype wire

/* File: tb/bsf_stage_model.sv */
`timescale 1ns/1ps
`default_nettype none
module bsf_stage_model (
    input wire logic clock, // System clock
    input wire bsf_pkg::bsf_drive_s drive, // Switch controls
    input wire logic en, // Enable pin level
    input wire logic supplyOk, // Supply above lockout
    input wire logic hot, // Die above shutdown point
    input wire logic overload, // Load above switch limit
    input wire logic [7:0] voutPct, // Output in percent of target
    output var bsf_pkg::bsf_sense_s sense // Comparator outputs
);
    // ----
    // Coil and comparators
    // ----
    logic coilOn_q;
    // Coil current needs one cycle of conduction to reach the limit
    always_ff @(posedge clock) begin
        coilOn_q <= drive.highSideOn;
    end
    always_comb begin
        sense.enable = en;
        sense.uvloOk = supplyOk;
        sense.overTemp = hot;
        sense.tempRecovered = !hot;
        sense.curLimit = drive.highSideOn
            && (overload || (drive.hysteretic && coilOn_q));
        sense.zeroCurrent = !coilOn_q;
        sense.outAbove90 = voutPct >= 8'h5a;
        sense.outAbove96 = voutPct >= 8'h60;
        sense.overVoltage = voutPct > 8'h73;
        sense.belowHold = !overload;
    end
endmodule
`default_nettype wire

/* File: tb/bsf_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module bsf_checker #(
    parameter int STEP_CYCLES = 2000, // Clocks per step
    parameter int OSC_DIV = 40 // Clocks per period
) (
    input wire logic clock, // Clock
    input wire logic sys_rst, // Reset
    input wire bsf_pkg::bsf_sense_s sense, // Comparators
    input wire bsf_pkg::bsf_drive_s drive, // Stage controls
    input wire logic oscTick // Oscillator pulse
);
    // ----
    // Helpers
    // ----
    int gap_q;
    int age_q;
    logic seen_q;
    logic [1:0] lvl_q;
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    always_ff @(posedge clock) begin
        gap_q <= (sys_rst || oscTick) ? 0 : gap_q + 1;
        seen_q <= !sys_rst && (seen_q || oscTick);
    end
    // Age only counts inside soft-start, so reset time never leaks in
    always_ff @(posedge clock) begin
        lvl_q <= drive.limitLevel;
        age_q <= (drive.limitLevel != lvl_q || !drive.hysteretic) ? 0
            : age_q + 1;
    end
    sequence offSw;
        !drive.highSideOn && !drive.lowSideOn;
    endsequence
    sequence stepUp;
        $changed(drive.limitLevel) && drive.hysteretic
            && $past(drive.hysteretic) && !sense.outAbove90;
    endsequence
    // ----
    // Assertions
    // ----
    en_off_a:
        assert property (!sense.enable [*3] |=> offSw ##0 !drive.refOn)
        else $error("switches on while disabled");
    supply_off_a:
        assert property (!sense.uvloOk [*3] |=> offSw ##0 !drive.refOn)
        else $error("switches on in lockout");
    hot_off_a:
        assert property (sense.overTemp [*3] |=> offSw)
        else $error("switches on while hot");
    ov_off_a:
        assert property (sense.overVoltage [*3] |=> offSw)
        else $error("switches on in overvoltage");
    ss_nofold_a:
        assert property (drive.hysteretic |-> !drive.foldback)
        else $error("foldback during soft-start");
    prebias_keep_a:
        assert property (drive.hysteretic |-> !drive.lowSideOn)
        else $error("low side on during soft-start");
    step_order_a:
        assert property (stepUp |->
            drive.limitLevel == $past(drive.limitLevel) + 2'h1)
        else $error("limit level out of order");
    step_time_a:
        assert property (stepUp |->
            age_q >= STEP_CYCLES - 3 && age_q <= STEP_CYCLES + 2)
        else $error("limit level held wrong time");
    osc_period_a:
        assert property (oscTick && seen_q |-> gap_q == OSC_DIV - 1)
        else $error("oscillator period wrong");
endmodule
bind bsf_supervisor bsf_checker #(.STEP_CYCLES(STEP_CYCLES),
    .OSC_DIV(OSC_DIV)) u_bsf_checker (.clock(clock), .sys_rst(sys_rst),
    .sense(sense), .drive(drive), .oscTick(oscTick));
`default_nettype wire

/* File: tb/tb_buck_startup_fault_supervisor.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_buck_startup_fault_supervisor;
    localparam int STEP = 20;
    localparam int DIV = 40;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic en = 1'b0;
    logic supplyOk = 1'b0;
    logic hot = 1'b0;
    logic overload = 1'b0;
    logic [7:0] voutPct = 8'h00;
    bsf_pkg::bsf_sense_s sense;
    bsf_pkg::bsf_drive_s drive;
    logic oscTick;
    int num_errors = 0;
    int tests_run = 0;
    int cycles = 0;
    always #5 clock = ~clock;
    bsf_supervisor #(.STEP_CYCLES(STEP), .OSC_DIV(DIV)) u_bsf_supervisor (
        .clock(clock), .sys_rst(sys_rst), .sense(sense), .drive(drive),
        .oscTick(oscTick));
    bsf_stage_model u_bsf_stage_model (.clock(clock), .drive(drive),
        .en(en), .supplyOk(supplyOk), .hot(hot), .overload(overload),
        .voutPct(voutPct), .sense(sense));
    // ----
    // Tasks
    // ----
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic complete_run();
        if (num_errors == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic offChk();
        repeat (5) @(posedge clock);
        chk({drive.highSideOn, drive.lowSideOn}, 2'h0);
    endtask
    task automatic restart();
        en <= 1'b0;
        repeat (6) @(posedge clock);
        en <= 1'b1;
    endtask
    // Expected levels are the step index; nLv of 0 skips that check
    task automatic startup(input int pA, pB, expDur, nLv);
        int dur;
        int n;
        logic [1:0] lv[$];
        logic hsSeen;
        dur = 0;
        n = 0;
        hsSeen = 1'b0;
        voutPct <= pA[7:0];
        while (drive.hysteretic !== 1'b1 && n < 400) begin
            @(posedge clock);
            n++;
        end
        while (drive.hysteretic === 1'b1 && dur < 400) begin
            if (lv.size() == 0 || lv[$] !== drive.limitLevel) begin
                lv.push_back(drive.limitLevel);
            end
            if (drive.limitLevel === bsf_pkg::LIM_40) begin
                voutPct <= pB[7:0];
            end
            chk(drive.lowSideOn, 1'b0);
            hsSeen |= drive.highSideOn;
            @(posedge clock);
            dur++;
        end
        chk(dur >= expDur - 5 && dur <= expDur + 5, 1'b1);
        chk(hsSeen, 1'b1);
        if (nLv > 0) begin
            chk(lv.size(), nLv);
            foreach (lv[i]) chk(lv[i], i);
        end
    endtask
    // ----
    // Run
    // ----
    always @(posedge clock) begin
        cycles++;
        if (cycles == 10000) begin
            num_errors++;
            complete_run();
        end
    end
    initial begin
        int p;
        logic seen;
        void'($urandom(32'h03ea));
        repeat (10) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        chk(drive, 7'h00);
        en <= 1'b1;
        repeat (60) @(posedge clock);
        chk(drive.refOn, 1'b0);
        supplyOk <= 1'b1;
        startup($urandom % 90, 50, 4 * STEP, 4);
        seen = 1'b0;
        repeat (2 * DIV) begin
            @(posedge clock);
            seen |= drive.highSideOn;
        end
        chk(seen, 1'b1);
        voutPct <= 8'h78;
        offChk();
        voutPct <= 8'h64;
        supplyOk <= 1'b0;
        offChk();
        supplyOk <= 1'b1;
        p = 90 + $urandom % 6;
        startup(p, p, 4 * STEP, 0);
        restart();
        startup($urandom % 90, 97, 2 * STEP + 4, 3);
        overload <= 1'b1;
        restart();
        startup(50, 50, 4 * STEP, 4);
        chk(drive.foldback, 1'b0);
        repeat (30 * DIV) @(posedge clock);
        chk(drive.foldback, 1'b0);
        repeat (4 * DIV) @(posedge clock);
        chk(drive.foldback, 1'b1);
        overload <= 1'b0;
        repeat (8) @(posedge clock);
        chk(drive.foldback, 1'b0);
        hot <= 1'b1;
        offChk();
        repeat (40) @(posedge clock);
        hot <= 1'b0;
        startup($urandom % 90, 50, 4 * STEP, 4);
        en <= 1'b0;
        offChk();
        chk(drive.refOn, 1'b0);
        complete_run();
    end
endmodule
`default_nettype wire
